// *** rtl/hwm_multiplier.sv ***
`timescale 1ns/10ps
`default_nettype none
module hwm_multiplier
    import hwm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic mul_en_i,
    input wire hwm_operands_t ops_i,
    input wire logic prod_high_we_i,
    input wire logic prod_low_we_i,
    input wire logic [7:0] wr_data_i,
    input wire logic flag_we_i,
    input wire logic [7:0] flag_wr_data_i,
    output var hwm_product_t prod_o,
    output logic [7:0] alu_flag_register_o,
    output logic mul_done_o
);
    // ****************************************
    // combinational product
    // ****************************************
    hwm_product_t prod_d;
    hwm_product_t prod_q;
    logic [7:0] flag_q;
    logic done_q;
    hwm_state_t state_q;

    hwm_mul8_core u_core (
        .ops_i (ops_i), // RULE_05
        .prod_o (prod_d)
    );

    // ****************************************
    // product register pair
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prod_q <= {HWM_PROD_RST, HWM_PROD_RST};
        end
        else if (mul_en_i)
        begin
            // a multiply beats a direct write in the same cycle
            prod_q <= prod_d; // RULE_01 RULE_03 RULE_09
        end
        else
        begin
            if (prod_high_we_i)
            begin
                prod_q.product_high_byte <= wr_data_i;
            end
            if (prod_low_we_i)
            begin
                prod_q.product_low_byte <= wr_data_i;
            end
        end
    end

    // ****************************************
    // alu flags, untouched by multiply
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            flag_q <= HWM_FLAG_RST;
        end
        else if (flag_we_i && !mul_en_i)
        begin
            flag_q <= flag_wr_data_i; // RULE_04
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= HWM_IDLE;
            done_q <= 1'b0;
        end
        else
        begin
            state_q <= mul_en_i ? HWM_MUL : HWM_IDLE;
            done_q <= mul_en_i; // RULE_01
        end
    end

    assign prod_o = prod_q;
    assign alu_flag_register_o = flag_q;
    assign mul_done_o = done_q;

    // ****************************************
    // reference product for the checks
    // ****************************************
    // built apart from the core so a broken core cannot hide itself
    logic [15:0] ref_prod_q;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ref_prod_q <= {HWM_PROD_RST, HWM_PROD_RST};
        end
        else if (mul_en_i)
        begin
            ref_prod_q <= 16'(ops_i.working_register) * 16'(ops_i.file_operand);
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    property p_one_cycle;
        @(posedge clk_i) disable iff (!rst_n_i)
        mul_en_i |=> (prod_o == $past(ops_i.working_register) * $past(ops_i.file_operand));
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("product wrong after multiply"); // RULE_01

    property p_high_byte;
        @(posedge clk_i) disable iff (!rst_n_i)
        mul_en_i |=> prod_o.product_high_byte == ref_prod_q[15:8];
    endproperty
    a_high_byte: assert property (p_high_byte) else $error("high byte mismatch"); // RULE_03

    property p_low_byte;
        @(posedge clk_i) disable iff (!rst_n_i)
        mul_en_i |=> prod_o.product_low_byte == ref_prod_q[7:0];
    endproperty
    a_low_byte: assert property (p_low_byte) else $error("low byte mismatch"); // RULE_03

    property p_unsigned;
        @(posedge clk_i) disable iff (!rst_n_i)
        (mul_en_i && ops_i == 16'hFFFF) |=> prod_o == 16'hFE01;
    endproperty
    a_unsigned: assert property (p_unsigned) else $error("not unsigned full width"); // RULE_02

    property p_flags_kept;
        @(posedge clk_i) disable iff (!rst_n_i)
        mul_en_i |=> $stable(alu_flag_register_o);
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flags changed by multiply"); // RULE_04

    property p_operand_src;
        @(posedge clk_i) disable iff (!rst_n_i)
        (mul_en_i && ops_i.working_register == 8'h00) |=> prod_o == 16'h0000;
    endproperty
    a_operand_src: assert property (p_operand_src) else $error("operand source wrong"); // RULE_05

    property p_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!mul_en_i && !prod_high_we_i && !prod_low_we_i) |=> $stable(prod_o);
    endproperty
    a_hold: assert property (p_hold) else $error("product changed without cause"); // RULE_09

    // ****************************************
    // direct writes and flags
    // ****************************************
    property p_direct_high;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!mul_en_i && prod_high_we_i) |=> prod_o.product_high_byte == $past(wr_data_i);
    endproperty
    a_direct_high: assert property (p_direct_high) else $error("high write lost"); // RULE_09

    property p_direct_low;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!mul_en_i && prod_low_we_i) |=> prod_o.product_low_byte == $past(wr_data_i);
    endproperty
    a_direct_low: assert property (p_direct_low) else $error("low write lost"); // RULE_09

    property p_high_kept;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!mul_en_i && !prod_high_we_i) |=> $stable(prod_o.product_high_byte);
    endproperty
    a_high_kept: assert property (p_high_kept) else $error("high byte moved"); // RULE_09

    property p_low_kept;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!mul_en_i && !prod_low_we_i) |=> $stable(prod_o.product_low_byte);
    endproperty
    a_low_kept: assert property (p_low_kept) else $error("low byte moved"); // RULE_09

    property p_flag_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        (flag_we_i && !mul_en_i) |=> alu_flag_register_o == $past(flag_wr_data_i);
    endproperty
    a_flag_write: assert property (p_flag_write) else $error("flag write lost"); // RULE_04

    property p_flag_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        !flag_we_i |=> $stable(alu_flag_register_o);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flags moved"); // RULE_04

    // ****************************************
    // control checks
    // ****************************************
    property p_done_pulse;
        @(posedge clk_i) disable iff (!rst_n_i)
        mul_en_i |=> mul_done_o;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done missing"); // RULE_01

    property p_done_low;
        @(posedge clk_i) disable iff (!rst_n_i)
        !mul_en_i |=> !mul_done_o;
    endproperty
    a_done_low: assert property (p_done_low) else $error("done without multiply"); // RULE_01

    property p_state_onehot;
        @(posedge clk_i) disable iff (!rst_n_i)
        $onehot(state_q);
    endproperty
    a_state_onehot: assert property (p_state_onehot) else $error("bad state"); // RULE_01

    // ****************************************
    // coverage
    // ****************************************
    c_mul: cover property (@(posedge clk_i) disable iff (!rst_n_i) mul_en_i ##1 mul_en_i);
    c_wr: cover property (@(posedge clk_i) disable iff (!rst_n_i) prod_high_we_i && !mul_en_i);
    c_flag: cover property (@(posedge clk_i) disable iff (!rst_n_i) flag_we_i ##1 mul_en_i);
    c_signed_ops: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        mul_en_i && ops_i.working_register[7] && ops_i.file_operand[7]);
    c_refused: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        mul_en_i && prod_high_we_i);
endmodule // hwm_multiplier
`default_nettype wire

// *** rtl/hwm_pkg.sv ***
// Overview of operation
// RULE_01 - An 8 by 8 multiply completes in one instruction cycle, product ready for the next instruction.
// RULE_02 - Both operands are unsigned and the full 16-bit product is kept without truncation.
// RULE_03 - The upper product byte goes to the high byte register, the lower to the low byte register.
// RULE_04 - A multiply leaves every ALU status flag exactly as it was.
// RULE_05 - One operand is the working register, the other the addressed file register.
// RULE_06 - Software forms a signed 8 by 8 product by subtracting the other operand from the high byte per set sign bit.
// RULE_07 - Software forms a 16 by 16 product from four partial products accumulated with carry into four bytes.
// RULE_08 - Software corrects a signed 16 by 16 product by subtracting the other operand from the upper half per negative operand.
// RULE_09 - Both product bytes update together at the end of a multiply cycle and otherwise hold until a multiply or direct write.
`default_nettype none
package hwm_pkg;
    localparam int HWM_OP_W = 8;
    localparam int HWM_PROD_W = 16;
    localparam int HWM_FLAG_W = 8;
    localparam logic [7:0] HWM_PROD_RST = 8'h00;
    localparam logic [7:0] HWM_FLAG_RST = 8'h00;
    localparam int HWM_MUL_CYCLES = 1;

    typedef struct packed {
        logic [7:0] working_register;
        logic [7:0] file_operand;
    } hwm_operands_t;

    typedef struct packed {
        logic [7:0] product_high_byte;
        logic [7:0] product_low_byte;
    } hwm_product_t;

    typedef enum logic [1:0] {
        HWM_IDLE = 2'b01,
        HWM_MUL = 2'b10
    } hwm_state_t;
endpackage
`default_nettype wire

// *** rtl/hwm_mul8_core.sv ***
`timescale 1ns/10ps
`default_nettype none
module hwm_mul8_core
    import hwm_pkg::*;
(
    input wire hwm_operands_t ops_i,
    output var hwm_product_t prod_o
);
    logic [15:0] full;
    // zero-extended operands keep the product unsigned and full width
    assign full = {8'h00, ops_i.working_register} * {8'h00, ops_i.file_operand}; // RULE_02
    assign prod_o = full;
endmodule // hwm_mul8_core
`default_nettype wire

// *** tb/hwm_sw_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module hwm_sw_model
    import hwm_pkg::*;
(
    input wire hwm_operands_t ops_i,
    input wire hwm_product_t prod_i,
    output logic [15:0] signed_o
);
    // software sign fix-up, applied after the unsigned multiply
    always_comb signed_o = prod_i
        - {(ops_i.file_operand[7] ? ops_i.working_register : 8'h00), 8'h00}
        - {(ops_i.working_register[7] ? ops_i.file_operand : 8'h00), 8'h00};
endmodule // hwm_sw_model
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
    import hwm_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, mul_en_i = 1'b0, hw_i = 1'b0, lw_i = 1'b0, fw_i = 1'b0;
    logic [7:0] wd_i = 8'h00, fd_i = 8'h00, flags_o;
    hwm_operands_t ops_i = '0;
    hwm_product_t prod_o;
    logic done_o;
    logic [15:0] sgn;
    int mismatches = 0, samples_checked = 0, cycles = 0;
    always #5 clk_i = ~clk_i;
    hwm_multiplier dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .mul_en_i(mul_en_i), .ops_i(ops_i),
        .prod_high_we_i(hw_i), .prod_low_we_i(lw_i), .wr_data_i(wd_i), .flag_we_i(fw_i),
        .flag_wr_data_i(fd_i), .prod_o(prod_o), .alu_flag_register_o(flags_o),
        .mul_done_o(done_o));
    hwm_sw_model sw (.ops_i(ops_i), .prod_i(prod_o), .signed_o(sgn));
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            mismatches++;
            complete_run();
        end
    end
    // ****************
    // scenarios
    // ****************
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // leaves mul_en_i high so callers can chain multiplies back to back
    task automatic mul(input logic [7:0] a, input logic [7:0] b);
        ops_i = {a, b};
        mul_en_i = 1'b1;
        @(negedge clk_i);
        chk("done", 16'h0001, {15'h0000, done_o});
        chk("prod", 16'(a) * 16'(b), prod_o);
    endtask
    task automatic t_unsigned();
        logic [15:0] v [5] = '{16'hFFFF, 16'h8002, 16'h00C3, 16'h01FF, 16'hA55A};
        foreach (v[i]) mul(v[i][15:8], v[i][7:0]);
        mul_en_i = 1'b0;
        repeat (3) @(negedge clk_i);
        chk("hold", 16'h00A5 * 16'h005A, prod_o);
        chk("done", 16'h0000, {15'h0000, done_o});
    endtask
    task automatic t_writes();
        fd_i = 8'h5C;
        fw_i = 1'b1;
        @(negedge clk_i);
        fd_i = 8'hA3;
        wd_i = 8'h77;
        hw_i = 1'b1;
        mul(8'h10, 8'h10);
        chk("flags", 16'h005C, {8'h00, flags_o});
        mul_en_i = 1'b0;
        @(negedge clk_i);
        chk("flags", 16'h00A3, {8'h00, flags_o});
        chk("wr_hi", 16'h7700, prod_o);
        hw_i = 1'b0;
        fw_i = 1'b0;
        lw_i = 1'b1;
        wd_i = 8'h3C;
        @(negedge clk_i);
        lw_i = 1'b0;
        chk("wr_lo", 16'h773C, prod_o);
    endtask
    task automatic t_signed();
        mul(8'hFE, 8'h05);
        chk("signed", 16'hFFF6, sgn);
        mul(8'h80, 8'h80);
        chk("signed", 16'h4000, sgn);
        mul_en_i = 1'b0;
    endtask
    task automatic t_wide(input logic [15:0] x, input logic [15:0] y);
        logic [31:0] acc;
        logic [31:0] acc_s;
        logic signed [31:0] sx;
        logic signed [31:0] sy;
        acc = 32'h0;
        for (int k = 0; k < 4; k++)
        begin
            mul(x[8*(k/2)+:8], y[8*(k%2)+:8]);
            acc += {16'h0000, prod_o} << (8 * (k/2 + k%2));
        end
        mul_en_i = 1'b0;
        chk("wide_lo", 16'(32'(x) * 32'(y)), acc[15:0]);
        chk("wide_hi", 16'((32'(x) * 32'(y)) >> 16), acc[31:16]);
        // sign fix-up on the upper half, one subtraction per negative operand
        acc_s = acc - (y[15] ? {x, 16'h0000} : 32'h0) - (x[15] ? {y, 16'h0000} : 32'h0);
        sx = $signed(x);
        sy = $signed(y);
        chk("swide_lo", 16'(sx * sy), acc_s[15:0]);
        chk("swide_hi", 16'((sx * sy) >>> 16), acc_s[31:16]);
    endtask
    task automatic t_reset();
        rst_n_i = 1'b0;
        @(negedge clk_i);
        chk("rst_prod", 16'h0000, prod_o);
        chk("rst_flags", 16'h0000, {8'h00, flags_o});
        chk("rst_done", 16'h0000, {15'h0000, done_o});
        rst_n_i = 1'b1;
        @(negedge clk_i);
        chk("rst_prod", 16'h0000, prod_o);
        mul(8'h0F, 8'h11);
        mul_en_i = 1'b0;
    endtask
    task automatic complete_run();
        if (mismatches == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(negedge clk_i);
        rst_n_i = 1'b1;
        @(negedge clk_i);
        chk("reset", 16'h0000, prod_o);
        t_unsigned();
        t_writes();
        t_signed();
        t_wide(16'hFEDC, 16'hBA98);
        t_wide(16'h1234, 16'hF00F);
        t_reset();
        complete_run();
    end
endmodule // tb
`default_nettype wire
